// File: hdl/ppfs_defines.vh
`ifndef PPFS_DEFINES_VH
`define PPFS_DEFINES_VH

// line counts and positions in the flat pad vector
`define PPFS_NUM_LINES     21
`define PPFS_A_BASE        0
`define PPFS_A_LINES       8
`define PPFS_B_BASE        8
`define PPFS_B_LINES       8
`define PPFS_B_LOW_LINES   4
`define PPFS_C_BASE        16
`define PPFS_C_LINES       5

// per-line mode codes, three bits each
`define PPFS_MODE_W        3
`define PPFS_MODE_IN       3'h0
`define PPFS_MODE_IN_PULL  3'h1
`define PPFS_MODE_IRQ      3'h2
`define PPFS_MODE_ANALOG   3'h3
`define PPFS_MODE_OD       3'h4
`define PPFS_MODE_PP       3'h5

// shared-function line indices
`define PPFS_IDX_TIMER     17
`define PPFS_IDX_RLD_IN    14
`define PPFS_IDX_RLD_OUT   15
`define PPFS_IDX_SPI_DIN   18
`define PPFS_IDX_SPI_DOUT  19
`define PPFS_IDX_SPI_CLK   20

// clock divider select
`define PPFS_DIV_W         2
`define PPFS_DIV_1         2'h0
`define PPFS_DIV_2         2'h1
`define PPFS_DIV_4         2'h2
`define PPFS_DIVCNT_W      2
`define PPFS_DIVCNT_ZERO   2'h0
`define PPFS_DIVCNT_ONE    2'h1
`define PPFS_DIVCNT_THREE  2'h3

`endif

// File: hdl/ppfs_pad_cell.v
`timescale 1ns/1ps
`default_nettype none
`include "ppfs_defines.vh"

module ppfs_pad_cell #(
  parameter HAS_ANALOG = 1
) (
  // clock and reset
  input  wire                    clk_i,
  input  wire                    rst_b_i,
  // configuration and data
  input  wire [`PPFS_MODE_W-1:0] mode_i,
  input  wire                    dout_i,
  input  wire                    alt_en_i,
  input  wire                    alt_oe_i,
  input  wire                    alt_out_i,
  // pad side
  input  wire                    pad_i,
  output reg                     pad_o,
  output reg                     pad_oe_o,
  output reg                     pull_o,
  output reg                     ana_o,
  output reg                     level_o
);

  reg sync1;
  reg sync2;
  reg sync3;

  // three-stage input; a change is taken once stages two and three agree
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1   <= 1'b1;
      sync2   <= 1'b1;
      sync3   <= 1'b1;
      level_o <= 1'b1;
    end else begin
      sync1 <= pad_i;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3) begin
        level_o <= sync3;
      end
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pad_o    <= 1'b0;
      pad_oe_o <= 1'b0;
      pull_o   <= 1'b0;
      ana_o    <= 1'b0;
    end else if (alt_en_i) begin
      pad_o    <= alt_out_i;
      pad_oe_o <= alt_oe_i;
      pull_o   <= 1'b0;
      ana_o    <= 1'b0;
    end else begin
      pad_o    <= 1'b0;
      pad_oe_o <= 1'b0;
      pull_o   <= 1'b0;
      ana_o    <= 1'b0;
      case (mode_i)
        `PPFS_MODE_IN_PULL: pull_o <= 1'b1;
        `PPFS_MODE_IRQ:     pull_o <= 1'b1;
        // no converter tap on lines without one: plain input instead
        `PPFS_MODE_ANALOG:  ana_o  <= (HAS_ANALOG != 0);
        `PPFS_MODE_OD:      pad_oe_o <= ~dout_i;
        `PPFS_MODE_PP: begin
          pad_o    <= dout_i;
          pad_oe_o <= 1'b1;
        end
        default: pull_o <= 1'b0;
      endcase
    end
  end

endmodule // ppfs_pad_cell
`default_nettype wire

// File: hdl/ppfs_top.v
`timescale 1ns/1ps
`default_nettype none
`include "ppfs_defines.vh"

module ppfs_top #(
  parameter B_LOW_RESET_PULLUP = 1
) (
  // clock and reset
  input  wire                                     clk_i,
  input  wire                                     rst_b_i,
  // line configuration writes
  input  wire [`PPFS_A_LINES*`PPFS_MODE_W-1:0]    first_port_mode_i,
  input  wire                                     first_port_mode_we_i,
  input  wire [`PPFS_B_LINES*`PPFS_MODE_W-1:0]    second_port_mode_i,
  input  wire                                     second_port_mode_we_i,
  input  wire [`PPFS_C_LINES*`PPFS_MODE_W-1:0]    third_port_mode_i,
  input  wire                                     third_port_mode_we_i,
  // port output data
  input  wire [`PPFS_NUM_LINES-1:0]               port_data_i,
  // timer pin
  input  wire                                     timer_out_en_i,
  input  wire                                     timer_data_bit_i,
  input  wire                                     timer_timeout_i,
  output reg                                      timer_pin_in_o,
  // reload timer
  input  wire                                     reload_out_sel_i,
  input  wire                                     reload_timer_output_i,
  output reg                                      reload_timer_input_o,
  // serial interface
  input  wire                                     spi_en_i,
  input  wire                                     spi_dout_i,
  input  wire                                     spi_clk_out_i,
  input  wire                                     spi_clk_oe_i,
  output reg                                      spi_din_o,
  output reg                                      spi_clk_in_o,
  // interrupt pin and port interrupts
  input  wire                                     nmi_pin_i,
  input  wire                                     nmi_ack_i,
  output wire                                     nmi_pullup_o,
  output reg                                      nmi_pend_o,
  output reg                                      port_irq_o,
  // clock divider and core reset
  input  wire [`PPFS_DIV_W-1:0]                   clk_div_sel_i,
  output reg                                      core_tick_o,
  output reg                                      core_rst_b_o,
  // pads
  input  wire [`PPFS_NUM_LINES-1:0]               pad_in_i,
  output wire [`PPFS_NUM_LINES-1:0]               pad_out_o,
  output wire [`PPFS_NUM_LINES-1:0]               pad_oe_o,
  output wire [`PPFS_NUM_LINES-1:0]               pad_pullup_o,
  output wire [`PPFS_NUM_LINES-1:0]               pad_analog_o,
  output wire [`PPFS_NUM_LINES-1:0]               pad_level_o
);

  localparam [`PPFS_MODE_W-1:0] B_LOW_RST =
    (B_LOW_RESET_PULLUP != 0) ? `PPFS_MODE_IN_PULL : `PPFS_MODE_IN;
  localparam [`PPFS_B_LINES*`PPFS_MODE_W-1:0] B_RST =
    {{(`PPFS_B_LINES-`PPFS_B_LOW_LINES){`PPFS_MODE_IN}},
     {`PPFS_B_LOW_LINES{B_LOW_RST}}};
  localparam [`PPFS_A_LINES*`PPFS_MODE_W-1:0] A_RST =
    {`PPFS_A_LINES{`PPFS_MODE_IN}};
  localparam [`PPFS_C_LINES*`PPFS_MODE_W-1:0] C_RST =
    {`PPFS_C_LINES{`PPFS_MODE_IN}};

  reg  [`PPFS_A_LINES*`PPFS_MODE_W-1:0]   mode_a;
  reg  [`PPFS_B_LINES*`PPFS_MODE_W-1:0]   mode_b;
  reg  [`PPFS_C_LINES*`PPFS_MODE_W-1:0]   mode_c;
  wire [`PPFS_NUM_LINES*`PPFS_MODE_W-1:0] mode_all;
  reg  [`PPFS_NUM_LINES-1:0]              alt_en;
  reg  [`PPFS_NUM_LINES-1:0]              alt_oe;
  reg  [`PPFS_NUM_LINES-1:0]              alt_out;
  reg                                     timer_level;
  reg                                     nmi_s1;
  reg                                     nmi_s2;
  reg                                     nmi_s3;
  reg                                     nmi_prev;
  reg                                     rst_s1;
  reg  [`PPFS_DIVCNT_W-1:0]               div_cnt;
  reg  [`PPFS_DIVCNT_W-1:0]               div_last;
  reg                                     next_irq;
  wire                                    nmi_fall;
  integer                                 k;

  assign mode_all     = {mode_c, mode_b, mode_a};
  assign nmi_pullup_o = 1'b1;

  // mode registers; second-port low lines come up per build option
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_a <= A_RST;
      mode_b <= B_RST;
      mode_c <= C_RST;
    end else begin
      if (first_port_mode_we_i) begin
        mode_a <= first_port_mode_i;
      end
      if (second_port_mode_we_i) begin
        mode_b <= second_port_mode_i;
      end
      if (third_port_mode_we_i) begin
        mode_c <= third_port_mode_i;
      end
    end
  end

  // timer data bit is latched on time-out, held until the next one
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timer_level <= 1'b0;
    end else if (timer_timeout_i) begin
      timer_level <= timer_data_bit_i;
    end
  end

  // alternate-function overlay; cleared bits leave the port bit alone
  always @* begin
    alt_en  = {`PPFS_NUM_LINES{1'b0}};
    alt_oe  = {`PPFS_NUM_LINES{1'b0}};
    alt_out = {`PPFS_NUM_LINES{1'b0}};
    alt_en[`PPFS_IDX_TIMER]     = timer_out_en_i;
    alt_oe[`PPFS_IDX_TIMER]     = 1'b1;
    alt_out[`PPFS_IDX_TIMER]    = timer_level;
    alt_en[`PPFS_IDX_RLD_OUT]   = reload_out_sel_i;
    alt_oe[`PPFS_IDX_RLD_OUT]   = 1'b1;
    alt_out[`PPFS_IDX_RLD_OUT]  = reload_timer_output_i;
    alt_en[`PPFS_IDX_SPI_DOUT]  = spi_en_i;
    alt_oe[`PPFS_IDX_SPI_DOUT]  = 1'b1;
    alt_out[`PPFS_IDX_SPI_DOUT] = spi_dout_i;
    alt_en[`PPFS_IDX_SPI_CLK]   = spi_en_i;
    alt_oe[`PPFS_IDX_SPI_CLK]   = spi_clk_oe_i;
    alt_out[`PPFS_IDX_SPI_CLK]  = spi_clk_out_i;
  end

  genvar g;
  generate
    for (g = 0; g < `PPFS_NUM_LINES; g = g + 1) begin : g_line
      ppfs_pad_cell #(
        .HAS_ANALOG ((g < `PPFS_B_BASE) || (g >= `PPFS_C_BASE))
      ) u_cell (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b_i),
        .mode_i    (mode_all[g*`PPFS_MODE_W +: `PPFS_MODE_W]),
        .dout_i    (port_data_i[g]),
        .alt_en_i  (alt_en[g]),
        .alt_oe_i  (alt_oe[g]),
        .alt_out_i (alt_out[g]),
        .pad_i     (pad_in_i[g]),
        .pad_o     (pad_out_o[g]),
        .pad_oe_o  (pad_oe_o[g]),
        .pull_o    (pad_pullup_o[g]),
        .ana_o     (pad_analog_o[g]),
        .level_o   (pad_level_o[g])
      );
    end
  endgenerate

  // true when the line's mode is one of the three input modes
  function is_input;
    input [`PPFS_MODE_W-1:0] m;
    begin
      is_input = (m == `PPFS_MODE_IN) || (m == `PPFS_MODE_IN_PULL) ||
                 (m == `PPFS_MODE_IRQ);
    end
  endfunction

  // timer and reload inputs go low-idle when the line is not an input; serial inputs go low while spi_en_i is low
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timer_pin_in_o       <= 1'b0;
      reload_timer_input_o <= 1'b0;
      spi_din_o            <= 1'b0;
      spi_clk_in_o         <= 1'b0;
      port_irq_o           <= 1'b0;
    end else begin
      timer_pin_in_o <= (!timer_out_en_i) &&
        is_input(mode_all[`PPFS_IDX_TIMER*`PPFS_MODE_W +: `PPFS_MODE_W]) &&
        pad_level_o[`PPFS_IDX_TIMER];
      reload_timer_input_o <=
        is_input(mode_all[`PPFS_IDX_RLD_IN*`PPFS_MODE_W +: `PPFS_MODE_W]) &&
        pad_level_o[`PPFS_IDX_RLD_IN];
      spi_din_o    <= spi_en_i && pad_level_o[`PPFS_IDX_SPI_DIN];
      spi_clk_in_o <= spi_en_i && pad_level_o[`PPFS_IDX_SPI_CLK];
      port_irq_o   <= next_irq;
    end
  end

  // port interrupt: any irq-mode line held low, unless taken by an alternate function, requests service
  always @* begin
    next_irq = 1'b0;
    for (k = 0; k < `PPFS_NUM_LINES; k = k + 1) begin
      if ((mode_all[k*`PPFS_MODE_W +: `PPFS_MODE_W] == `PPFS_MODE_IRQ) &&
          !alt_en[k] && !pad_level_o[k]) begin
        next_irq = 1'b1;
      end
    end
  end

  // interrupt pin: synchronised, then falling edge; a new edge beats ack
  assign nmi_fall = nmi_prev && !nmi_s3 && (nmi_s2 == nmi_s3);

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nmi_s1     <= 1'b1;
      nmi_s2     <= 1'b1;
      nmi_s3     <= 1'b1;
      nmi_prev   <= 1'b1;
      nmi_pend_o <= 1'b0;
    end else begin
      nmi_s1 <= nmi_pin_i;
      nmi_s2 <= nmi_s1;
      nmi_s3 <= nmi_s2;
      if (nmi_s2 == nmi_s3) begin
        nmi_prev <= nmi_s3;
      end
      if (nmi_fall) begin
        nmi_pend_o <= 1'b1;
      end else if (nmi_ack_i) begin
        nmi_pend_o <= 1'b0;
      end
    end
  end

  // core reset: asserted at once, released in step with the clock
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1       <= 1'b0;
      core_rst_b_o <= 1'b0;
    end else begin
      rst_s1       <= 1'b1;
      core_rst_b_o <= rst_s1;
    end
  end

  // divider gives a tick per core cycle instead of a gated clock
  always @* begin
    case (clk_div_sel_i)
      `PPFS_DIV_2: div_last = `PPFS_DIVCNT_ONE;
      `PPFS_DIV_4: div_last = `PPFS_DIVCNT_THREE;
      default:     div_last = `PPFS_DIVCNT_ZERO;
    endcase
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_cnt     <= `PPFS_DIVCNT_ZERO;
      core_tick_o <= 1'b0;
    end else if (div_cnt >= div_last) begin
      div_cnt     <= `PPFS_DIVCNT_ZERO;
      core_tick_o <= 1'b1;
    end else begin
      div_cnt     <= div_cnt + `PPFS_DIVCNT_ONE;
      core_tick_o <= 1'b0;
    end
  end

endmodule // ppfs_top
`default_nettype wire

// File: bench/ppfs_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppfs_board_model (
  // clock
  input  wire logic        clk_i,
  // device pad side
  input  wire logic [20:0] pad_out_i,
  input  wire logic [20:0] pad_oe_i,
  input  wire logic [20:0] pad_pullup_i,
  // board drive chosen by the bench
  input  wire logic [20:0] ext_i,
  input  wire logic [20:0] ext_en_i,
  output wire logic [20:0] pad_in_o
);
  logic [20:0] junk = 21'h0;
  // floating lines wander so a stale level never passes for a valid one
  always @(posedge clk_i) junk <= ~junk;
  assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_en_i & ext_i)
                  | (~pad_oe_i & ~ext_en_i & (pad_pullup_i | junk));
endmodule // ppfs_board_model
`default_nettype wire

// File: bench/ppfs_props.sv
`timescale 1ns/1ps
`default_nettype none
module ppfs_props #(
  parameter B_LOW_RESET_PULLUP = 1
) (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  // controls
  input wire logic        timer_out_en_i,
  input wire logic        timer_data_bit_i,
  input wire logic        timer_timeout_i,
  input wire logic        reload_out_sel_i,
  input wire logic        reload_timer_output_i,
  input wire logic        spi_en_i,
  input wire logic        spi_dout_i,
  input wire logic        nmi_pin_i,
  input wire logic        nmi_ack_i,
  input wire logic [1:0]  clk_div_sel_i,
  // outputs
  input wire logic        nmi_pullup_o,
  input wire logic        nmi_pend_o,
  input wire logic        core_tick_o,
  input wire logic        core_rst_b_o,
  input wire logic [20:0] pad_out_o,
  input wire logic [20:0] pad_oe_o,
  input wire logic [20:0] pad_pullup_o
);
  localparam logic [3:0] LOW_PULL = (B_LOW_RESET_PULLUP != 0) ? 4'hf : 4'h0;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_nmi_pull_up: assert property (nmi_pullup_o)
    else $error("nmi pull-up missing");
  a_nmi_edge_set: assert property ($fell(nmi_pin_i) && !nmi_ack_i
    |-> ##[2:6] nmi_pend_o) else $error("nmi edge lost");
  a_tick_div_four: assert property ((clk_div_sel_i == 2'h2)[*5] ##0
    core_tick_o |=> ((!core_tick_o)[*3] ##1 core_tick_o)
    or (##[0:3] clk_div_sel_i != 2'h2)) else $error("divide by four wrong");
  // release seen at the third edge: two flops after the pin goes high
  a_rst_release: assert property ($rose(core_rst_b_o)
    |-> $past(rst_b_i, 2) && !$past(rst_b_i, 3))
    else $error("core reset timing");
  a_reset_pull_ups: assert property ($rose(core_rst_b_o)
    |-> pad_pullup_o[11:8] == LOW_PULL && pad_oe_o == 21'h0)
    else $error("reset pad state wrong");
  a_timer_pin_out: assert property (timer_timeout_i
    && timer_out_en_i ##1 timer_out_en_i[*2] |-> pad_oe_o[17]
    && pad_out_o[17] == $past(timer_data_bit_i, 2)) else $error("timer pin");
  a_reload_pin_out: assert property (reload_out_sel_i |=> pad_oe_o[15]
    && pad_out_o[15] == $past(reload_timer_output_i))
    else $error("reload pin");
  a_spi_data_out: assert property (spi_en_i |=> pad_oe_o[19]
    && pad_out_o[19] == $past(spi_dout_i)) else $error("serial data pin");
  c_nmi: cover property (nmi_pend_o);
  c_timer: cover property (timer_timeout_i && timer_out_en_i);
  c_div4: cover property (clk_div_sel_i == 2'h2 && core_tick_o);
endmodule // ppfs_props
bind ppfs_top ppfs_props #(.B_LOW_RESET_PULLUP(B_LOW_RESET_PULLUP)) u_props (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .timer_out_en_i(timer_out_en_i),
  .timer_data_bit_i(timer_data_bit_i), .timer_timeout_i(timer_timeout_i),
  .reload_out_sel_i(reload_out_sel_i), .spi_en_i(spi_en_i),
  .reload_timer_output_i(reload_timer_output_i), .spi_dout_i(spi_dout_i),
  .nmi_pin_i(nmi_pin_i), .nmi_ack_i(nmi_ack_i), .clk_div_sel_i(clk_div_sel_i),
  .nmi_pullup_o(nmi_pullup_o), .nmi_pend_o(nmi_pend_o),
  .core_tick_o(core_tick_o), .core_rst_b_o(core_rst_b_o),
  .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .pad_pullup_o(pad_pullup_o));
`default_nettype wire

// File: bench/port_pin_function_select_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppfs_defines.vh"
module port_pin_function_select_tb_top;
  logic        clk = 0, rst_b = 0, fmwe = 0, smwe = 0, tmwe = 0, ten = 0;
  logic        tbit = 0, tto = 0, rsel = 0, rout = 0, spen = 0, sdout = 0;
  logic        sclk = 0, sclkoe = 0, nmi = 1, ack = 0;
  logic [1:0]  div = 2'h0;
  logic [62:0] md = '0;
  logic [20:0] pdata = '0, ext = '0, exten = '0;
  logic [31:0] seed = 32'h68aa6be1;
  logic [3:0]  e;
  logic        irq_e;
  int          error_cnt = 0, total_checks = 0, cyc = 0, i, k, n;
  wire         tpin, rin, sdin, sclkin, pull, pend, pirq, tick, crst;
  wire  [20:0] pin, pout, poe, ppu, pana, plev;

  ppfs_top #(.B_LOW_RESET_PULLUP(1)) dut (
    .clk_i(clk), .rst_b_i(rst_b), .first_port_mode_i(md[23:0]),
    .first_port_mode_we_i(fmwe), .second_port_mode_i(md[47:24]),
    .second_port_mode_we_i(smwe), .third_port_mode_i(md[62:48]),
    .third_port_mode_we_i(tmwe), .port_data_i(pdata),
    .timer_out_en_i(ten), .timer_data_bit_i(tbit), .timer_timeout_i(tto),
    .timer_pin_in_o(tpin), .reload_out_sel_i(rsel),
    .reload_timer_output_i(rout), .reload_timer_input_o(rin),
    .spi_en_i(spen), .spi_dout_i(sdout), .spi_clk_out_i(sclk),
    .spi_clk_oe_i(sclkoe), .spi_din_o(sdin), .spi_clk_in_o(sclkin),
    .nmi_pin_i(nmi), .nmi_ack_i(ack), .nmi_pullup_o(pull),
    .nmi_pend_o(pend), .port_irq_o(pirq), .clk_div_sel_i(div),
    .core_tick_o(tick), .core_rst_b_o(crst), .pad_in_i(pin),
    .pad_out_o(pout), .pad_oe_o(poe), .pad_pullup_o(ppu),
    .pad_analog_o(pana), .pad_level_o(plev));
  ppfs_board_model board (.clk_i(clk), .pad_out_i(pout), .pad_oe_i(poe),
    .pad_pullup_i(ppu), .ext_i(ext), .ext_en_i(exten), .pad_in_o(pin));

  initial begin
    forever #12.5 clk = ~clk;
  end

  function logic [31:0] xs;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    xs = seed;
  endfunction

  // {oe, out, pull, analog} for a plain port line
  function logic [3:0] pexp(input logic [2:0] m, input logic d, a);
    case (m)
      `PPFS_MODE_IN_PULL, `PPFS_MODE_IRQ: pexp = 4'b0010;
      `PPFS_MODE_ANALOG: pexp = {3'b000, a};
      `PPFS_MODE_OD: pexp = {~d, 3'b000};
      `PPFS_MODE_PP: pexp = {1'b1, d, 2'b00};
      default: pexp = 4'h0;
    endcase
  endfunction

  task chk(input logic [31:0] got, exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task test_done;
    $display("checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task do_reset;
    rst_b = 0;
    repeat (16) @(negedge clk);
    chk(crst, 0, "core reset held");
    rst_b = 1;
    @(negedge clk);
    @(negedge clk);
    chk(crst, 1, "core reset release");
    chk(ppu, 21'h000f00, "reset pull-ups");
    chk(poe, 0, "reset drivers");
    $display("reset test done");
  endtask

  // mode writes land one edge after we, pads one edge later
  task setm(input logic [62:0] m);
    md = m;
    {fmwe, smwe, tmwe} = 3'b111;
    @(negedge clk);
    {fmwe, smwe, tmwe} = 3'b000;
    @(negedge clk);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      test_done;
    end
  end

  initial begin
    do_reset;
    for (k = 0; k < 30; k++) begin
      // spare codes 6 and 7 must act as plain input
      for (i = 0; i < 21; i++) md[3*i +: 3] = (k < 8) ? k : xs() % 8;
      pdata = xs();
      ext = xs();
      exten = xs();
      setm(md);
      repeat (6) @(negedge clk);
      irq_e = 1'b0;
      for (i = 0; i < 21; i++) begin
        e = pexp(md[3*i +: 3], pdata[i], i < 8 || i > 15);
        chk({poe[i], pout[i], ppu[i], pana[i]}, e, "pad");
        if (e[3] | exten[i] | e[1])
          chk(plev[i], e[3] ? e[2] : exten[i] ? ext[i] : 1'b1, "lvl");
        if (md[3*i +: 3] == `PPFS_MODE_IRQ && exten[i] && !ext[i])
          irq_e = 1'b1;
      end
      chk(pirq, irq_e, "port irq");
    end
    $display("mode test done");
    setm(63'h0);
    spen = 1;
    exten = 21'h1fffff;
    for (k = 0; k < 4; k++) begin
      ext = xs();
      {sdout, sclk} = xs();
      sclkoe = k[0];
      repeat (7) @(negedge clk);
      chk(tpin, ext[17], "timer input");
      chk(rin, ext[14], "reload input");
      chk(sdin, ext[18], "serial data in");
      chk({poe[19], pout[19]}, {1'b1, sdout}, "serial data out");
      chk(poe[20], sclkoe, "serial clock oe");
      chk(sclkin, sclkoe ? sclk : ext[20], "serial clock in");
    end
    spen = 0;
    sclkoe = 0;
    do_reset;
    ten = 1;
    for (k = 0; k < 4; k++) begin
      tbit = xs();
      tto = 1;
      @(negedge clk);
      tto = 0;
      repeat (2) @(negedge clk);
      chk({poe[17], pout[17]}, {1'b1, tbit}, "timer output");
    end
    ten = 0;
    repeat (2) @(negedge clk);
    chk(poe[17], 0, "timer pin released");
    rsel = 1;
    rout = xs();
    repeat (2) @(negedge clk);
    chk({poe[15], pout[15]}, {1'b1, rout}, "reload output");
    rsel = 0;
    $display("alternate test done");
    nmi = 0;
    for (n = 0; n < 8 && pend !== 1'b1; n++) @(negedge clk);
    chk(pend, 1, "nmi caught");
    ack = 1;
    @(negedge clk);
    ack = 0;
    nmi = 1;
    repeat (6) @(negedge clk);
    chk({pend, pull}, 2'b01, "nmi cleared");
    // select code 3 is spare and divides by one
    for (k = 0; k < 4; k++) begin
      div = k;
      repeat (8) @(negedge clk);
      n = 0;
      repeat (16) begin
        @(negedge clk);
        n += tick;
      end
      chk(n, (k == 1) ? 8 : (k == 2) ? 4 : 16, "tick count");
    end
    $display("nmi and divider test done");
    test_done;
  end
endmodule // port_pin_function_select_tb_top
`default_nettype wire
